// *** core/operand_address_generator.sv ***
// Operand address generator with APB register access
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator #(
   parameter int unsigned APB_AW = 8
) (
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire logic [APB_AW-1:0]             paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output var  logic [31:0]                   prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   output var  operand_addr_pkg::mem_req_t    memOut,
   input  wire operand_addr_pkg::mem_rsp_t    memIn,
   input  wire logic                          ccLoad,
   input  wire logic [3:0]                    ccIn,
   output var  logic [31:0]                   argListPointer
);
   import operand_addr_pkg::*;

   if (APB_AW < 8)
   begin : g_bad_aw
      $error("APB_AW must be at least 8");
   end

   typedef enum logic [1:0] {S_IDLE, S_DEREF, S_CHECK, S_COMMIT} state_t;

   // ****************************************************
   // State
   // ****************************************************
   state_t      state;
   logic [31:0] gpr [16];
   spec_t       spec;
   logic [31:0] disp;
   logic [31:0] statLong;
   logic [7:0]  byteVal;
   logic [31:0] ea;
   logic [31:0] operand;
   logic [31:0] pendBase;
   logic [31:0] idxOff;
   logic        wbEn;
   logic        done;
   logic        accViol;
   logic        privFault;
   logic        badSpec;

   // ****************************************************
   // Bus decode
   // ****************************************************
   wire [7:0]  regOff   = paddr[7:0];
   wire        hiZero   = (paddr >> 8) == '0;
   wire        isGpr    = hiZero && (regOff[7:6] == OFF_GPR_BASE[7:6]);
   wire [3:0]  gprSel   = regOff[5:2];
   wire        mapped   = hiZero && (regOff[1:0] == 2'h0)
                          && (isGpr || regOff <= OFF_BYTE_UNS);
   wire        busy     = state != S_IDLE;
   wire        apbSetup = psel && penable && !pready;
   wire        apbWr    = psel && penable && pready && pwrite && mapped;
   wire        startCmd = apbWr && regOff == OFF_CTRL
                          && pwdata[CTRL_START_BIT] && !busy;
   wire        cfgWr    = apbWr && !busy;

   // ****************************************************
   // Specifier decode
   // ****************************************************
   wire        modeBranch = spec.mode == MODE_BRANCH;
   wire [3:0]  baseSel    = modeBranch ? PC_INDEX : spec.baseReg;
   wire [31:0] base       = gpr[baseSel];
   wire [31:0] sizeBytes  = opSize(spec.dataType);
   wire [31:0] dispExt    = extendDisp(disp, spec.dispSize);
   wire [31:0] decBase    = base - sizeBytes;
   wire [31:0] incBase    = base + sizeBytes;
   wire [31:0] defBase    = base + LONG_BYTES;
   wire [31:0] dispAddr   = base + dispExt;
   wire [31:0] idxCalc    = spec.idxEn
                            ? gpr[spec.idxReg] * sizeBytes : 32'h0;
   wire [1:0]  curLevel   = statLong[LEVEL_LSB +: 2];
   wire        privBlock  = spec.priv && curLevel != PL_KERNEL;
   wire        needCheck  = spec.accType == AT_READ
                            || spec.accType == AT_WRITE
                            || spec.accType == AT_MODIFY;
   wire        chkRd      = spec.accType != AT_WRITE;
   wire        chkWr      = spec.accType != AT_READ;
   wire        badCombo   = spec.mode > MODE_BRANCH
                            || spec.dataType > DT_DOUBLE
                            || spec.accType > AT_BRANCH
                            || spec.dispSize > DS_LONG
                            || (modeBranch && spec.idxEn)
                            || (modeBranch && spec.dispSize == DS_LONG)
                            || (modeBranch != (spec.accType == AT_BRANCH));

   logic [31:0] firstAddr;
   logic [31:0] firstBase;
   logic        firstWb;
   logic        needDeref;

   always_comb
   begin
      firstAddr = base;
      firstBase = base;
      firstWb   = 1'b0;
      needDeref = 1'b0;
      unique case (spec.mode)
         MODE_AUTOINC:
         begin
            firstBase = incBase;
            firstWb   = 1'b1;
         end
         MODE_AUTODEC:
         begin
            firstAddr = decBase;
            firstBase = decBase;
            firstWb   = 1'b1;
         end
         MODE_AUTOIDEF:
         begin
            // With the counter as base this is absolute mode
            firstBase = defBase;
            firstWb   = 1'b1;
            needDeref = 1'b1;
         end
         MODE_DISP:    firstAddr = dispAddr;
         MODE_DISPDEF:
         begin
            firstAddr = dispAddr;
            needDeref = 1'b1;
         end
         MODE_BRANCH:  firstAddr = dispAddr;
         default:      firstAddr = base;
      endcase
   end

   wire [31:0] directEa = firstAddr + idxCalc;
   wire [31:0] derefEa  = memIn.data + idxOff;

   // ****************************************************
   // Read mux
   // ****************************************************
   logic [31:0] rdMux;

   always_comb
   begin
      rdMux = 32'h0;
      if (isGpr)
         rdMux = gpr[gprSel];
      else
         unique case (regOff)
            OFF_CTRL:     rdMux = {31'h0, busy};
            OFF_SPEC:     rdMux = spec;
            OFF_DISP:     rdMux = disp;
            OFF_STATUS:   rdMux = {28'h0, badSpec, privFault, accViol, done};
            OFF_EA:       rdMux = ea;
            OFF_OPERAND:  rdMux = operand;
            OFF_STAT_LONG: rdMux = statLong;
            OFF_BYTE_SGN: rdMux = sextByte(byteVal);
            OFF_BYTE_UNS: rdMux = {24'h0, byteVal};
            default:      rdMux = 32'h0;
         endcase
   end

   // ****************************************************
   // APB answer, one wait state
   // ****************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= apbSetup;
         pslverr <= apbSetup && !mapped;
         prdata  <= (apbSetup && mapped && !pwrite) ? rdMux : 32'h0;
      end
   end

   // ****************************************************
   // Configuration and status word
   // ****************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         spec    <= '0;
         disp    <= 32'h0;
         byteVal <= 8'h0;
         statLong <= STAT_RESET;
      end
      else
      begin
         if (cfgWr && regOff == OFF_SPEC)
            spec <= pwdata;
         if (cfgWr && regOff == OFF_DISP)
            disp <= pwdata;
         if (apbWr && regOff == OFF_BYTE_SGN)
            byteVal <= pwdata[7:0];
         if (apbWr && regOff == OFF_STAT_LONG)
            statLong <= pwdata;
         if (ccLoad)
            statLong[CC_LSB +: 4] <= ccIn;
      end
   end

   // ****************************************************
   // General registers
   // ****************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < 16; i++)
            gpr[i] <= GPR_RESET;
      end
      else if (state == S_COMMIT && wbEn)
         gpr[baseSel] <= pendBase;
      else if (cfgWr && isGpr)
         gpr[gprSel] <= pwdata;
   end

   assign argListPointer = gpr[ARG_PTR_INDEX];

   // ****************************************************
   // Sequencer
   // ****************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state     <= S_IDLE;
         memOut    <= '0;
         ea        <= 32'h0;
         operand   <= 32'h0;
         pendBase  <= 32'h0;
         idxOff    <= 32'h0;
         wbEn      <= 1'b0;
         done      <= 1'b0;
         accViol   <= 1'b0;
         privFault <= 1'b0;
         badSpec   <= 1'b0;
      end
      else
      begin
         unique case (state)
            S_IDLE:
            begin
               if (startCmd)
               begin
                  done      <= 1'b0;
                  accViol   <= 1'b0;
                  privFault <= 1'b0;
                  badSpec   <= 1'b0;
                  operand   <= 32'h0;
                  pendBase  <= firstBase;
                  wbEn      <= firstWb;
                  idxOff    <= idxCalc;
                  if (privBlock)
                  begin
                     privFault <= 1'b1;
                     done      <= 1'b1;
                  end
                  else if (badCombo)
                  begin
                     badSpec <= 1'b1;
                     done    <= 1'b1;
                  end
                  else if (needDeref)
                  begin
                     memOut <= '{req: 1'b1, probe: 1'b0, chkRd: 1'b1,
                                 chkWr: 1'b0, level: curLevel,
                                 addr: firstAddr};
                     state  <= S_DEREF;
                  end
                  else
                  begin
                     ea <= directEa;
                     if (needCheck)
                     begin
                        memOut <= '{req: 1'b1, probe: 1'b1, chkRd: chkRd,
                                    chkWr: chkWr, level: curLevel,
                                    addr: directEa};
                        state  <= S_CHECK;
                     end
                     else
                        state <= S_COMMIT;
                  end
               end
            end
            S_DEREF:
            begin
               if (memIn.ack)
               begin
                  if (memIn.fault)
                  begin
                     memOut.req <= 1'b0;
                     accViol    <= 1'b1;
                     done       <= 1'b1;
                     state      <= S_IDLE;
                  end
                  else
                  begin
                     ea <= derefEa;
                     if (needCheck)
                     begin
                        memOut <= '{req: 1'b1, probe: 1'b1, chkRd: chkRd,
                                    chkWr: chkWr, level: curLevel,
                                    addr: derefEa};
                        state  <= S_CHECK;
                     end
                     else
                     begin
                        memOut.req <= 1'b0;
                        state      <= S_COMMIT;
                     end
                  end
               end
            end
            S_CHECK:
            begin
               if (memIn.ack)
               begin
                  memOut.req <= 1'b0;
                  if (memIn.fault)
                  begin
                     accViol <= 1'b1;
                     done    <= 1'b1;
                     state   <= S_IDLE;
                  end
                  else
                     state <= S_COMMIT;
               end
            end
            S_COMMIT:
            begin
               if (spec.accType == AT_ADDRESS || modeBranch)
                  operand <= ea;
               done  <= 1'b1;
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule : operand_address_generator
`default_nettype wire

// *** inc/operand_addr_pkg.sv ***
// Constants, types and helpers shared by the operand address generator
`default_nettype none
package operand_addr_pkg;

   // ****************************************************
   // Register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_SPEC      = 8'h04;
   localparam logic [7:0] OFF_DISP      = 8'h08;
   localparam logic [7:0] OFF_STATUS    = 8'h0C;
   localparam logic [7:0] OFF_EA        = 8'h10;
   localparam logic [7:0] OFF_OPERAND   = 8'h14;
   localparam logic [7:0] OFF_STAT_LONG = 8'h18;
   localparam logic [7:0] OFF_BYTE_SGN  = 8'h1C;
   localparam logic [7:0] OFF_BYTE_UNS  = 8'h20;
   localparam logic [7:0] OFF_GPR_BASE  = 8'h40;

   // ****************************************************
   // Field positions and reset values
   // ****************************************************
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_BUSY_BIT  = 0;
   localparam int unsigned ST_DONE_BIT    = 0;
   localparam int unsigned ST_VIOL_BIT    = 1;
   localparam int unsigned ST_PRIV_BIT    = 2;
   localparam int unsigned ST_BAD_BIT     = 3;
   localparam int unsigned CC_LSB         = 0;
   localparam int unsigned LEVEL_LSB      = 24;
   localparam logic [31:0] STAT_RESET     = 32'h0000_0000;
   localparam logic [31:0] GPR_RESET      = 32'h0000_0000;

   // ****************************************************
   // Encodings
   // ****************************************************
   localparam logic [3:0] MODE_REGDEF   = 4'h0;
   localparam logic [3:0] MODE_AUTOINC  = 4'h1;
   localparam logic [3:0] MODE_AUTODEC  = 4'h2;
   localparam logic [3:0] MODE_AUTOIDEF = 4'h3;
   localparam logic [3:0] MODE_DISP     = 4'h4;
   localparam logic [3:0] MODE_DISPDEF  = 4'h5;
   localparam logic [3:0] MODE_BRANCH   = 4'h6;
   localparam logic [2:0] DT_BYTE   = 3'h0;
   localparam logic [2:0] DT_WORD   = 3'h1;
   localparam logic [2:0] DT_LONG   = 3'h2;
   localparam logic [2:0] DT_QUAD   = 3'h3;
   localparam logic [2:0] DT_FLOAT  = 3'h4;
   localparam logic [2:0] DT_DOUBLE = 3'h5;
   localparam logic [2:0] AT_READ    = 3'h0;
   localparam logic [2:0] AT_WRITE   = 3'h1;
   localparam logic [2:0] AT_MODIFY  = 3'h2;
   localparam logic [2:0] AT_ADDRESS = 3'h3;
   localparam logic [2:0] AT_BRANCH  = 3'h4;
   localparam logic [1:0] DS_BYTE = 2'h0;
   localparam logic [1:0] DS_WORD = 2'h1;
   localparam logic [1:0] DS_LONG = 2'h2;
   localparam logic [1:0] PL_KERNEL = 2'h0;
   localparam logic [1:0] PL_EXEC   = 2'h1;
   localparam logic [1:0] PL_SUPER  = 2'h2;
   localparam logic [1:0] PL_USER   = 2'h3;
   localparam logic [3:0] PC_INDEX      = 4'hF;
   localparam logic [3:0] ARG_PTR_INDEX = 4'hC;
   localparam logic [31:0] LONG_BYTES   = 32'h0000_0004;

   // ****************************************************
   // Carriers
   // ****************************************************
   typedef struct packed {
      logic [3:0] rsvHigh;
      logic [1:0] dispSize;
      logic       rsv25;
      logic       priv;
      logic       rsv23;
      logic [2:0] accType;
      logic       rsv19;
      logic [2:0] dataType;
      logic [3:0] idxReg;
      logic [2:0] rsv11;
      logic       idxEn;
      logic [3:0] baseReg;
      logic [3:0] mode;
   } spec_t;

   typedef struct packed {
      logic        req;
      logic        probe;
      logic        chkRd;
      logic        chkWr;
      logic [1:0]  level;
      logic [31:0] addr;
   } mem_req_t;

   typedef struct packed {
      logic        ack;
      logic        fault;
      logic [31:0] data;
   } mem_rsp_t;

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [31:0] opSize(input logic [2:0] dt);
      unique case (dt)
         DT_BYTE:            opSize = 32'h0000_0001;
         DT_WORD:            opSize = 32'h0000_0002;
         DT_QUAD, DT_DOUBLE: opSize = 32'h0000_0008;
         default:            opSize = 32'h0000_0004;
      endcase
   endfunction : opSize

   function automatic logic [31:0] sextByte(input logic [7:0] b);
      sextByte = {{24{b[7]}}, b};
   endfunction : sextByte

   function automatic logic [31:0] extendDisp(input logic [31:0] d,
                                               input logic [1:0]  ds);
      unique case (ds)
         DS_BYTE: extendDisp = sextByte(d[7:0]);
         DS_WORD: extendDisp = {{16{d[15]}}, d[15:0]};
         default: extendDisp = d;
      endcase
   endfunction : extendDisp

endpackage : operand_addr_pkg
`default_nettype wire

// *** tb/operand_addr_chk.sv ***
// Port checker for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module operand_addr_chk (
   input wire logic                       clk,
   input wire logic                       rstn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire operand_addr_pkg::mem_req_t memOut,
   input wire operand_addr_pkg::mem_rsp_t memIn
);
   import operand_addr_pkg::*;
   // ******************
   // Port properties
   // ******************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_wait_state: assert property
      ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("ready not after one wait state");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_req_hold: assert property
      (memOut.req && !memIn.ack |=> memOut.req && $stable(memOut))
      else $error("memory request changed before answer");
   a_probe_drop: assert property
      (memOut.req && memIn.ack && memOut.probe |=> !memOut.req)
      else $error("request kept after answer");
   a_fetch_read: assert property
      (memOut.req && !memOut.probe |-> memOut.chkRd && !memOut.chkWr)
      else $error("pointer fetch not a plain read");
   a_probe_rights: assert property
      (memOut.req && memOut.probe |-> memOut.chkRd || memOut.chkWr)
      else $error("probe checks no right");
endmodule : operand_addr_chk
`default_nettype wire

// *** tb/mem_partner.sv ***
// Memory and translation model answering fetches and access checks
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire operand_addr_pkg::mem_req_t memOut,
   output var  operand_addr_pkg::mem_rsp_t memIn,
   input  wire logic [3:0]                 lat,
   input  wire logic [31:0]                faultAddr,
   output var  logic [1:0]                 lastChk
);
   import operand_addr_pkg::*;
   logic [3:0] cnt;
   wire        waiting = memOut.req && !memIn.ack;
   wire        hit     = waiting && cnt >= lat;
   always_ff @(posedge clk)
      if (!rstn)
      begin
         memIn   <= '0;
         cnt     <= '0;
         lastChk <= '0;
      end
      else if (hit)
      begin
         memIn.ack   <= 1'b1;
         memIn.fault <= memOut.addr == faultAddr;
         memIn.data  <= memOut.addr + 32'h0001_0000;
         lastChk     <= {memOut.chkRd, memOut.chkWr};
         cnt         <= '0;
      end
      else
      begin
         memIn.ack   <= 1'b0;
         memIn.fault <= 1'b0;
         memIn.data  <= ~memIn.data;
         cnt         <= waiting ? cnt + 4'h1 : 4'h0;
      end
endmodule : mem_partner
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import operand_addr_pkg::*;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic        ccLoad, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, argListPointer, faultAddr, rd;
   logic [3:0]  ccIn, lat;
   logic [1:0]  lastChk;
   mem_req_t    memOut;
   mem_rsp_t    memIn;
   int          fails, checksDone;
   int          sizes [6] = '{1, 2, 4, 8, 4, 8};
   operand_address_generator #(.APB_AW(8)) i_dut (.clk(clk), .rstn(rstn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .memOut(memOut), .memIn(memIn), .ccLoad(ccLoad), .ccIn(ccIn),
      .argListPointer(argListPointer));
   mem_partner i_mem (.clk(clk), .rstn(rstn), .memOut(memOut),
      .memIn(memIn), .lat(lat), .faultAddr(faultAddr), .lastChk(lastChk));
   // ******************
   // Tasks
   // ******************
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd  = prdata;
      err = pslverr;
      if (pready !== 1'b1)
      begin
         fails++;
         conclude();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   function automatic logic [7:0] ga(input logic [3:0] n);
      ga = OFF_GPR_BASE + {2'b00, n, 2'b00};
   endfunction : ga
   function automatic logic [31:0] sp(input logic [3:0] m, b,
      input logic [2:0] dt, ac, input logic ie = 1'b0,
      input logic [3:0] ix = 4'h0, input logic pv = 1'b0,
      input logic [1:0] ds = DS_BYTE);
      sp = {4'h0, ds, 1'b0, pv, 1'b0, ac, 1'b0, dt, ix, 3'h0, ie, b, m};
   endfunction : sp
   task automatic run(input logic [31:0] spec, input logic [3:0] st,
                      input logic [31:0] ea);
      int n;
      apb(1'b1, OFF_SPEC, spec);
      apb(1'b1, OFF_CTRL, 32'h1);
      n = 0;
      do
      begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end
      while (rd[ST_DONE_BIT] !== 1'b1 && n < 50);
      if (rd[ST_DONE_BIT] !== 1'b1)
      begin
         fails++;
         conclude();
      end
      check("status", rd, {28'h0, st});
      if (st == 4'h1)
      begin
         apb(1'b0, OFF_EA, 32'h0);
         check("address", rd, ea);
      end
   endtask : run
   // ******************
   // Tests
   // ******************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {rstn, psel, penable, pwrite, ccLoad, paddr, pwdata, ccIn} = '0;
      {lat, faultAddr, fails, checksDone} = {4'h0, 32'hFFFF_FFFF, 64'h0};
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b0, OFF_STAT_LONG, 32'h0);
      check("status reset", rd, STAT_RESET);
      for (int t = 0; t < 6; t++)
      begin
         apb(1'b1, ga(4'h2), 32'h1000);
         run(sp(MODE_AUTOINC, 4'h2, 3'(t), AT_READ), 4'h1, 32'h1000);
         apb(1'b0, ga(4'h2), 32'h0);
         check("inc", rd, 32'h1000 + sizes[t]);
         run(sp(MODE_AUTODEC, 4'h2, 3'(t), AT_WRITE), 4'h1, 32'h1000);
         apb(1'b0, ga(4'h2), 32'h0);
         check("dec", rd, 32'h1000);
      end
      $display("test steps done");
      lat <= 4'h5;
      apb(1'b1, ga(4'h4), 32'h3000);
      run(sp(MODE_AUTOIDEF, 4'h4, DT_BYTE, AT_MODIFY), 4'h1, 32'h0001_3000);
      check("rights", {30'h0, lastChk}, 32'h3);
      apb(1'b0, ga(4'h4), 32'h0);
      check("deferred", rd, 32'h3004);
      apb(1'b1, ga(PC_INDEX), 32'h0500);
      run(sp(MODE_AUTOIDEF, PC_INDEX, DT_WORD, AT_ADDRESS), 4'h1, 32'h0001_0500);
      apb(1'b0, OFF_OPERAND, 32'h0);
      check("operand", rd, 32'h0001_0500);
      apb(1'b0, ga(PC_INDEX), 32'h0);
      check("pc", rd, 32'h0504);
      $display("test deferred done");
      apb(1'b1, OFF_DISP, 32'h0000_80F0);
      run(sp(MODE_BRANCH, PC_INDEX, DT_BYTE, AT_BRANCH), 4'h1, 32'h04F4);
      run(sp(MODE_BRANCH, PC_INDEX, DT_WORD, AT_BRANCH, 1'b0, 4'h0, 1'b0,
             DS_WORD), 4'h1, 32'hFFFF_85F4);
      apb(1'b1, ga(4'h5), 32'h4000);
      apb(1'b1, ga(4'h6), 32'h3);
      apb(1'b1, OFF_DISP, 32'h0000_1280);
      run(sp(MODE_DISP, 4'h5, DT_LONG, AT_READ, 1'b1, 4'h6), 4'h1, 32'h3F8C);
      run(sp(MODE_DISPDEF, 4'h5, DT_WORD, AT_WRITE, 1'b1, 4'h6, 1'b0,
             DS_WORD), 4'h1, 32'h0001_5286);
      apb(1'b0, OFF_OPERAND, 32'h0);
      check("no operand", rd, 32'h0);
      run(sp(MODE_REGDEF, 4'h5, DT_LONG, AT_READ), 4'h1, 32'h4000);
      apb(1'b0, ga(4'h5), 32'h0);
      check("base kept", rd, 32'h4000);
      $display("test displacement done");
      faultAddr <= 32'h7000;
      apb(1'b1, ga(4'h7), 32'h7000);
      run(sp(MODE_AUTOINC, 4'h7, DT_LONG, AT_READ), 4'h3, 32'h0);
      apb(1'b0, ga(4'h7), 32'h0);
      check("kept", rd, 32'h7000);
      for (int l = 1; l < 4; l++)
      begin
         apb(1'b1, OFF_STAT_LONG, {6'h0, 2'(l), 24'h0});
         run(sp(MODE_AUTOINC, 4'h2, DT_BYTE, AT_READ, 1'b0, 4'h0, 1'b1),
             4'h5, 32'h0);
      end
      apb(1'b1, OFF_STAT_LONG, 32'h0);
      run(sp(MODE_AUTOINC, 4'h2, DT_BYTE, AT_READ, 1'b0, 4'h0, 1'b1),
          4'h1, 32'h1000);
      apb(1'b0, ga(4'h2), 32'h0);
      check("privileged", rd, 32'h1001);
      run(32'h0000_0007, 4'h9, 32'h0);
      apb(1'b0, 8'h3C, 32'h0);
      check("unmapped", {31'h0, err}, 32'h1);
      $display("test faults done");
      apb(1'b1, OFF_BYTE_SGN, 32'h0000_0180);
      apb(1'b0, OFF_BYTE_SGN, 32'h0);
      check("signed", rd, 32'hFFFF_FF80);
      apb(1'b0, OFF_BYTE_UNS, 32'h0);
      check("unsigned", rd, 32'h0000_0080);
      apb(1'b1, OFF_BYTE_SGN, 32'h0000_007F);
      apb(1'b0, OFF_BYTE_SGN, 32'h0);
      check("positive", rd, 32'h0000_007F);
      ccIn   <= 4'hA;
      ccLoad <= 1'b1;
      @(posedge clk);
      ccLoad <= 1'b0;
      apb(1'b0, OFF_STAT_LONG, 32'h0);
      check("flags", rd, 32'h0000_000A);
      apb(1'b1, ga(ARG_PTR_INDEX), 32'h0000_1234);
      check("arglist", argListPointer, 32'h0000_1234);
      $display("test registers done");
      conclude();
   end
endmodule : testbench
bind operand_address_generator operand_addr_chk i_chk (.clk(clk),
   .rstn(rstn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .memOut(memOut), .memIn(memIn));
`default_nettype wire
